// file: sdm_defines.svh
// Constants for the signed DSP multiply unit
//
// Contract
// - Difference-accumulate sets sticky overflow on accumulate overflow
// - High-word accumulate adds upper product word to accumulator
// - High-word subtract: accumulator minus upper product word
// - Rounding adds 0x80000000 before taking upper word
// - High-word accumulate and subtract keep condition flags
// - High-word product writes signed upper 32 bits
// - High-word product leaves condition flags untouched
// - Dual sum writes sum of two halfword products
// - Dual difference writes bottom product minus top product
// - Exchange swaps second operand halfwords for pairing
// - Dual sum sets sticky overflow on overflow; dual difference never overflows
// - Halfword pair selectors pick bottom or top independently
// - Halfword pair writes full signed 32-bit product
// - Word by halfword writes upper 32 of 48 bits
// - Word by halfword selector picks second operand halfword
// - Difference-accumulate: bottom minus top product, plus accumulator
// - Overflow flag sticky; only status write or reset clears it
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH

// ============================================================
// Widths
`define SDM_WORD_W     32
`define SDM_HALF_W     16
`define SDM_PROD_W     64
`define SDM_REG_IDX_W  4

// ============================================================
// Field positions
`define SDM_HALF_LO_MSB 15
`define SDM_HALF_HI_MSB 31
`define SDM_HALF_HI_LSB 16
`define SDM_WH_MSB      47
`define SDM_WH_LSB      16

// ============================================================
// Rounding, reset and latency values
`define SDM_ROUND_CONST 64'h0000_0000_8000_0000
`define SDM_ZERO_WORD   32'h0000_0000
`define SDM_Q_RESET     1'h0
`define SDM_LATENCY     2

`endif

// file: sdm_pkg.sv
// Types shared by the signed DSP multiply unit
`default_nettype none
package sdm_pkg;

    // ============================================================
    // Operations
    typedef enum logic [2:0] {
        SDM_HIGH_WORD_PRODUCT_ACCUMULATE        = 3'h0,
        SDM_HIGH_WORD_PRODUCT_SUBTRACT          = 3'h1,
        SDM_HIGH_WORD_PRODUCT                   = 3'h2,
        SDM_DUAL_PRODUCT_SUM                    = 3'h3,
        SDM_DUAL_PRODUCT_DIFFERENCE             = 3'h4,
        SDM_DUAL_PRODUCT_DIFFERENCE_ACCUMULATE  = 3'h5,
        SDM_HALFWORD_PAIR_PRODUCT               = 3'h6,
        SDM_WORD_BY_HALFWORD_PRODUCT            = 3'h7
    } sdm_op_t;

    // ============================================================
    // Issue request from the decoder
    typedef struct packed {
        logic        valid;
        sdm_op_t     op;
        logic        round;     // Round high-word results
        logic        exchange;  // Swap second operand halfwords
        logic        sel_a_top; // First operand halfword select
        logic        sel_b_top; // Second operand halfword select
        logic [3:0]  rd;
        logic [31:0] rn;
        logic [31:0] rm;
        logic [31:0] ra;
    } sdm_req_t;

    // ============================================================
    // Write-back to the register file
    typedef struct packed {
        logic        valid;
        logic [3:0]  rd;
        logic [31:0] value;
        logic        ovf;       // This operation overflowed
    } sdm_res_t;

endpackage
`default_nettype wire

// file: sdm_half_mul.sv
// Signed 16x16 halfword multiplier
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"
module sdm_half_mul (
    // Operands
    input  wire logic signed [`SDM_HALF_W-1:0] a,
    input  wire logic signed [`SDM_HALF_W-1:0] b,
    // Product
    output logic signed [`SDM_WORD_W-1:0]      prod
);
    // Full product never overflows 32 bits
    assign prod = a * b;
endmodule // sdm_half_mul
`default_nettype wire

// file: sdm_word_mul.sv
// Signed 32x32 word multiplier
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"
module sdm_word_mul (
    // Operands
    input  wire logic signed [`SDM_WORD_W-1:0] a,
    input  wire logic signed [`SDM_WORD_W-1:0] b,
    // Product
    output logic signed [`SDM_PROD_W-1:0]      prod
);
    // Full 64-bit signed product
    assign prod = a * b;
endmodule // sdm_word_mul
`default_nettype wire

// file: sdm_unit.sv
// Signed DSP multiply unit: two-stage datapath with sticky overflow
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"
module sdm_unit (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Issue from decoder
    input  wire sdm_pkg::sdm_req_t req,
    // Status register write of the overflow flag
    input  wire logic              q_wr_en,
    input  wire logic              q_wr_data,
    // Write-back
    output var  sdm_pkg::sdm_res_t res,
    output var  logic              q_flag
);
    import sdm_pkg::*;

    // Result two edges after the request is taken
    // No stall, no hazard check: a request may follow every cycle
    // Idle cycles pass as bubbles with a zero result word
    // Only dual sum and difference-accumulate can overflow
    // Products alone never overflow; a 33-bit sum detects it
    // Destination index passes unchecked; the issuer keeps it legal

    // ============================================================
    // Halfword select decode
    function automatic logic [`SDM_HALF_W-1:0] pick_half(input logic [`SDM_WORD_W-1:0] w, input logic top);
        pick_half = top ? w[`SDM_HALF_HI_MSB:`SDM_HALF_HI_LSB] : w[`SDM_HALF_LO_MSB:0];
    endfunction

    // Overflow of a 33-bit signed sum
    function automatic logic sum_ovf(input logic [`SDM_WORD_W:0] s);
        sum_ovf = s[`SDM_WORD_W] ^ s[`SDM_WORD_W-1];
    endfunction

    // ============================================================
    // Stage 1: operand capture, one short register per field group
    logic        stg_valid_reg;
    sdm_op_t     stg_op_reg;
    logic [3:0]  stg_mode_reg;
    logic [3:0]  stg_rd_reg;
    logic [31:0] stg_rn_reg;
    logic [31:0] stg_rm_reg;
    logic [31:0] stg_ra_reg;
    sdm_req_t    stg_reg;

    // Issue strobe; idle cycles flow through as bubbles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_valid_reg <= 1'h0;
        end else begin
            stg_valid_reg <= req.valid;
        end
    end

    // Operation code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_op_reg <= SDM_HIGH_WORD_PRODUCT_ACCUMULATE;
        end else begin
            stg_op_reg <= req.op;
        end
    end

    // Options: round, exchange and both halfword selects
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_mode_reg <= '0;
        end else begin
            stg_mode_reg <= {req.round, req.exchange, req.sel_a_top, req.sel_b_top};
        end
    end

    // Destination index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_rd_reg <= '0;
        end else begin
            stg_rd_reg <= req.rd;
        end
    end

    // First operand
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_rn_reg <= `SDM_ZERO_WORD;
        end else begin
            stg_rn_reg <= req.rn;
        end
    end

    // Second operand
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_rm_reg <= `SDM_ZERO_WORD;
        end else begin
            stg_rm_reg <= req.rm;
        end
    end

    // Accumulate operand
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_ra_reg <= `SDM_ZERO_WORD;
        end else begin
            stg_ra_reg <= req.ra;
        end
    end

    // Captured request as one bundle for the datapath
    assign stg_reg.valid = stg_valid_reg;
    assign stg_reg.op    = stg_op_reg;
    assign {stg_reg.round, stg_reg.exchange, stg_reg.sel_a_top, stg_reg.sel_b_top} = stg_mode_reg;
    assign stg_reg.rd    = stg_rd_reg;
    assign stg_reg.rn    = stg_rn_reg;
    assign stg_reg.rm    = stg_rm_reg;
    assign stg_reg.ra    = stg_ra_reg;

    // ============================================================
    // Operation decode
    wire logic is_pair    = (stg_reg.op == SDM_HALFWORD_PAIR_PRODUCT);
    wire logic is_wh      = (stg_reg.op == SDM_WORD_BY_HALFWORD_PRODUCT);

    // ============================================================
    // Word multiplier operands
    wire logic [`SDM_HALF_W-1:0] wh_half = pick_half(stg_reg.rm, stg_reg.sel_b_top);
    wire logic [`SDM_WORD_W-1:0] wh_ext  = {{`SDM_HALF_W{wh_half[`SDM_HALF_W-1]}}, wh_half};
    wire logic [`SDM_WORD_W-1:0] wm_b    = is_wh ? wh_ext : stg_reg.rm;
    logic [`SDM_PROD_W-1:0]      wm_prod;

    sdm_word_mul u_word_mul (
        .a    (stg_reg.rn),
        .b    (wm_b),
        .prod (wm_prod)
    );

    // ============================================================
    // High-word extraction with optional rounding
    wire logic [`SDM_PROD_W-1:0] rnd_add  = stg_reg.round ? `SDM_ROUND_CONST : '0;
    wire logic [`SDM_PROD_W-1:0] prod_rnd = wm_prod + rnd_add;
    wire logic [`SDM_WORD_W-1:0] hi_word  = prod_rnd[`SDM_PROD_W-1:`SDM_WORD_W];
    wire logic [`SDM_WORD_W-1:0] hw_acc   = stg_reg.ra + hi_word;
    wire logic [`SDM_WORD_W-1:0] hw_sub   = stg_reg.ra - hi_word;
    wire logic [`SDM_WORD_W-1:0] wh_word  = wm_prod[`SDM_WH_MSB:`SDM_WH_LSB];

    // ============================================================
    // Halfword lanes: lane 0 bottom, lane 1 top
    logic [`SDM_HALF_W-1:0] ln_a [2];
    logic [`SDM_HALF_W-1:0] ln_b [2];
    logic [`SDM_WORD_W-1:0] ln_p [2];

    // Lane 0 doubles as the halfword pair multiplier
    assign ln_a[0] = is_pair ? pick_half(stg_reg.rn, stg_reg.sel_a_top)
                             : stg_reg.rn[`SDM_HALF_LO_MSB:0];
    assign ln_b[0] = is_pair ? pick_half(stg_reg.rm, stg_reg.sel_b_top)
                             : pick_half(stg_reg.rm, stg_reg.exchange);

    // Lane 1: top of first operand, other half of second
    assign ln_a[1] = stg_reg.rn[`SDM_HALF_HI_MSB:`SDM_HALF_HI_LSB];
    assign ln_b[1] = pick_half(stg_reg.rm, !stg_reg.exchange);

    // One signed multiplier per lane
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            sdm_half_mul u_half_mul (
                .a    (ln_a[gi]),
                .b    (ln_b[gi]),
                .prod (ln_p[gi])
            );
        end
    endgenerate

    // ============================================================
    // Dual combine and accumulate with overflow detection
    wire logic [`SDM_WORD_W:0]   d_sum  = {ln_p[0][`SDM_WORD_W-1], ln_p[0]}
                                          + {ln_p[1][`SDM_WORD_W-1], ln_p[1]};
    wire logic [`SDM_WORD_W-1:0] d_diff = ln_p[0] - ln_p[1];
    wire logic [`SDM_WORD_W:0]   d_acc  = {d_diff[`SDM_WORD_W-1], d_diff}
                                          + {stg_reg.ra[`SDM_WORD_W-1], stg_reg.ra};

    // Signed overflow when the two top bits of a sum differ
    wire logic                   d_sum_ovf = sum_ovf(d_sum);
    wire logic                   d_acc_ovf = sum_ovf(d_acc);

    // ============================================================
    // Result select; high-word forms never report overflow
    logic [`SDM_WORD_W-1:0] val_next;
    logic                   ovf_next;

    always_comb begin
        val_next = `SDM_ZERO_WORD;
        ovf_next = 1'h0;
        case (stg_reg.op)
            SDM_HIGH_WORD_PRODUCT_ACCUMULATE: begin
                val_next = hw_acc;
            end
            SDM_HIGH_WORD_PRODUCT_SUBTRACT: begin
                val_next = hw_sub;
            end
            SDM_HIGH_WORD_PRODUCT: begin
                val_next = hi_word;
            end
            SDM_DUAL_PRODUCT_SUM: begin
                val_next = d_sum[`SDM_WORD_W-1:0];
                ovf_next = d_sum_ovf;
            end
            SDM_DUAL_PRODUCT_DIFFERENCE: begin
                val_next = d_diff;
            end
            SDM_DUAL_PRODUCT_DIFFERENCE_ACCUMULATE: begin
                val_next = d_acc[`SDM_WORD_W-1:0];
                ovf_next = d_acc_ovf;
            end
            SDM_HALFWORD_PAIR_PRODUCT: begin
                val_next = ln_p[0];
            end
            SDM_WORD_BY_HALFWORD_PRODUCT: begin
                val_next = wh_word;
            end
            default: begin
                val_next = `SDM_ZERO_WORD;
            end
        endcase
    end

    // ============================================================
    // Stage 2: write-back register, result and flag together
    sdm_res_t    res_next;
    logic        res_valid_reg;
    logic [3:0]  res_rd_reg;
    logic [31:0] res_value_reg;
    logic        res_ovf_reg;
    logic        q_reg;
    logic        q_next;

    // Overflow counts only for a live operation
    wire logic   q_set = stg_reg.valid & ovf_next;

    // Next write-back; bubbles carry a zero word
    assign res_next.valid = stg_reg.valid;
    assign res_next.rd    = stg_reg.rd;
    assign res_next.value = stg_reg.valid ? val_next : `SDM_ZERO_WORD;
    assign res_next.ovf   = q_set;

    // Sticky flag: an overflow wins over a clearing write
    assign q_next = q_set ? 1'h1 : (q_wr_en ? q_wr_data : q_reg);

    // Write-back strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid_reg <= 1'h0;
        end else begin
            res_valid_reg <= res_next.valid;
        end
    end

    // Destination index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_rd_reg <= '0;
        end else begin
            res_rd_reg <= res_next.rd;
        end
    end

    // Result word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_value_reg <= `SDM_ZERO_WORD;
        end else begin
            res_value_reg <= res_next.value;
        end
    end

    // Overflow pulse of this result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_ovf_reg <= 1'h0;
        end else begin
            res_ovf_reg <= res_next.ovf;
        end
    end

    // Sticky overflow flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= `SDM_Q_RESET;
        end else begin
            q_reg <= q_next;
        end
    end

    // Outputs straight from flip-flops, all loaded on one edge
    assign res.valid = res_valid_reg;
    assign res.rd    = res_rd_reg;
    assign res.value = res_value_reg;
    assign res.ovf   = res_ovf_reg;
    assign q_flag    = q_reg;

endmodule // sdm_unit
`default_nettype wire

// file: sdm_issuer_model.sv
// Reference arithmetic and the issuing decoder model
`timescale 1ns/1ps
`default_nettype none
// ====
// Expected result of one request
package sdm_ref_pkg;
    import sdm_pkg::*;
    // Returns {overflow, value}
    function automatic logic [32:0] ref_calc(sdm_req_t r);
        logic signed [15:0] m0, m1, ha, hb;
        logic signed [31:0] p0, p1, hp;
        logic signed [32:0] s;
        logic signed [63:0] w;
        logic signed [47:0] wh;
        m0 = r.exchange ? r.rm[31:16] : r.rm[15:0];
        m1 = r.exchange ? r.rm[15:0] : r.rm[31:16];
        ha = r.sel_a_top ? r.rn[31:16] : r.rn[15:0];
        hb = r.sel_b_top ? r.rm[31:16] : r.rm[15:0];
        p0 = $signed(r.rn[15:0]) * m0;
        p1 = $signed(r.rn[31:16]) * m1;
        hp = ha * hb;
        wh = $signed(r.rn) * hb;
        w = $signed(r.rn) * $signed(r.rm) + (r.round ? 64'sh0000_0000_8000_0000 : 64'sh0);
        s = (r.op == SDM_DUAL_PRODUCT_SUM) ? p0 + p1 : p0 - p1 + $signed(r.ra);
        case (r.op)
            SDM_HIGH_WORD_PRODUCT_ACCUMULATE: return {1'b0, w[63:32] + r.ra};
            SDM_HIGH_WORD_PRODUCT_SUBTRACT: return {1'b0, r.ra - w[63:32]};
            SDM_HIGH_WORD_PRODUCT: return {1'b0, w[63:32]};
            SDM_DUAL_PRODUCT_DIFFERENCE: return {1'b0, p0 - p1};
            SDM_HALFWORD_PAIR_PRODUCT: return {1'b0, hp};
            SDM_WORD_BY_HALFWORD_PRODUCT: return {1'b0, wh[47:16]};
            default: return {s[32] != s[31], s[31:0]};
        endcase
    endfunction
endpackage
// Decoder side: one request a cycle, released lines go stale-inverted
module sdm_issuer_model (
    // Clock
    input  wire logic              clk,
    // Request to the unit
    output var  sdm_pkg::sdm_req_t req
);
    import sdm_pkg::*;
    initial req = '0;
    // Present a request just after an edge
    task automatic issue(input sdm_req_t r);
        @(posedge clk);
        #1;
        r.valid = 1'b1;
        r.rd = 4'h1 + {1'b0, r.rd[2:0]};
        req = r;
    endtask
    // Withdraw the request
    task automatic idle();
        sdm_req_t t;
        @(posedge clk);
        #1;
        t = ~req;
        t.valid = 1'b0;
        req = t;
    endtask
endmodule // sdm_issuer_model
`default_nettype wire

// file: sdm_unit_monitor.sv
// Port assertions for the multiply unit
`timescale 1ns/1ps
`default_nettype none
module sdm_unit_monitor (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Watched ports
    input wire sdm_pkg::sdm_req_t req,
    input wire logic              q_wr_en,
    input wire logic              q_wr_data,
    input wire sdm_pkg::sdm_res_t res,
    input wire logic              q_flag
);
    import sdm_pkg::*;
    import sdm_ref_pkg::*;
    sdm_req_t    s1, s2;
    logic [32:0] e2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ====
    // Request pipeline copy for expectations
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= req;
            s2 <= s1;
        end
    end
    assign e2 = ref_calc(s2);
    // Timing, values and flag
    lat_fix_a: assert property (req.valid |-> ##2 res.valid) else $error("missing result");
    res_cause_a: assert property (res.valid |-> $past(req.valid, 2)) else $error("stray result");
    rd_pass_a: assert property (res.valid |-> res.rd == s2.rd) else $error("wrong rd");
    hw_val_a: assert property (res.valid && s2.op inside {[3'h0:3'h2]} |-> res.value == e2[31:0])
        else $error("high word value");
    dual_val_a: assert property (res.valid && s2.op inside {[3'h3:3'h5]} |-> res.value == e2[31:0])
        else $error("dual value");
    half_val_a: assert property (res.valid && s2.op[2:1] == 2'h3 |-> res.value == e2[31:0])
        else $error("halfword value");
    ovf_calc_a: assert property (res.valid |-> res.ovf == e2[32]) else $error("overflow");
    ovf_set_a: assert property (res.ovf |-> q_flag) else $error("flag not set");
    sticky_a: assert property (q_flag && !(q_wr_en && !q_wr_data) |=> q_flag) else $error("flag lost");
    clear_a: assert property (q_wr_en && !q_wr_data |=> res.ovf || !q_flag) else $error("no clear");
endmodule // sdm_unit_monitor
bind sdm_unit sdm_unit_monitor u_mon (.clk(clk), .rst_n(rst_n), .req(req), .q_wr_en(q_wr_en),
    .q_wr_data(q_wr_data), .res(res), .q_flag(q_flag));
`default_nettype wire

// file: sdm_unit_tb_top.sv
// Self-checking bench for the multiply unit
`timescale 1ns/1ps
`default_nettype none
module sdm_unit_tb_top;
    import sdm_pkg::*;
    import sdm_ref_pkg::*;
    logic        clk, rst_n, q_wr_en, q_wr_data, q_flag;
    sdm_req_t    req;
    sdm_res_t    res;
    int          n_fail, checks;
    logic [32:0] expq[$];
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sdm_issuer_model u_dec (.clk(clk), .req(req));
    sdm_unit DUT (.clk(clk), .rst_n(rst_n), .req(req), .q_wr_en(q_wr_en), .q_wr_data(q_wr_data),
        .res(res), .q_flag(q_flag));
    // ====
    // Compare, queue and drive helpers
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Each write-back against the oldest expectation
    always @(posedge clk) begin
        #2;
        if (res.valid === 1'b1)
            check({res.ovf, res.value}, (expq.size() != 0) ? expq.pop_front() : 33'h0_0000_0000);
    end
    task automatic run(input sdm_op_t op, input logic [3:0] fl, input logic [31:0] rn, rm, ra);
        sdm_req_t r;
        r = '0;
        r.op = op;
        {r.round, r.exchange, r.sel_a_top, r.sel_b_top} = fl;
        r.rd = rn[3:0];
        r.rn = rn;
        r.rm = rm;
        r.ra = ra;
        expq.push_back(ref_calc(r));
        u_dec.issue(r);
    endtask
    task automatic drain();
        int i;
        u_dec.idle();
        for (i = 0; i < 20 && expq.size() != 0; i++) @(posedge clk);
        #3;
        if (expq.size() != 0) begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic qwrite(input logic d);
        @(posedge clk);
        #1;
        q_wr_en = 1'b1;
        q_wr_data = d;
        @(posedge clk);
        #1;
        q_wr_en = 1'b0;
    endtask
    // ====
    // Scenarios, all back to back
    task automatic t_high_word();
        for (int k = 0; k < 6; k++)
            run(sdm_op_t'(k / 2), {k[0], 3'h0}, 32'hFFFF_FFFF, 32'h8000_0000, 32'h7FFF_FFFF);
        drain();
    endtask
    task automatic t_dual();
        for (int k = 0; k < 6; k++)
            run(sdm_op_t'(3 + k / 2), {1'h0, k[0], 2'h0}, 32'h8000_7FFF, 32'h8000_8001, 32'h8000_0000);
        run(SDM_DUAL_PRODUCT_DIFFERENCE_ACCUMULATE, 4'h0, 32'h0000_7FFF, 32'h0000_7FFF, 32'h7FFF_FFFF);
        drain();
    endtask
    task automatic t_half();
        for (int k = 0; k < 6; k++)
            run(sdm_op_t'(6 + k / 4), {2'h0, k[1:0]}, 32'h8000_7FFF, 32'hC001_3FFF, 32'h0);
        drain();
    endtask
    task automatic t_flag();
        qwrite(1'b0);
        check(q_flag, 1'b0);
        run(SDM_DUAL_PRODUCT_DIFFERENCE, 4'h0, 32'h8000_8000, 32'h7FFF_8000, 32'h0);
        run(SDM_HIGH_WORD_PRODUCT_ACCUMULATE, 4'h0, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h7FFF_FFFF);
        drain();
        check(q_flag, 1'b0);
        run(SDM_DUAL_PRODUCT_SUM, 4'h0, 32'h8000_8000, 32'h8000_8000, 32'h0);
        run(SDM_DUAL_PRODUCT_SUM, 4'h0, 32'h0001_0001, 32'h0001_0001, 32'h0);
        drain();
        check(q_flag, 1'b1);
        qwrite(1'b0);
        check(q_flag, 1'b0);
        run(SDM_DUAL_PRODUCT_SUM, 4'h0, 32'h8000_8000, 32'h8000_8000, 32'h0);
        fork
            u_dec.idle();
            qwrite(1'b0);
        join
        check(q_flag, 1'b1);
        drain();
    endtask
    // Reset mid-run drops the operation in flight and clears the flag
    task automatic t_reset();
        sdm_req_t r;
        r = '0;
        r.op = SDM_DUAL_PRODUCT_SUM;
        r.rn = 32'h8000_8000;
        r.rm = 32'h8000_8000;
        u_dec.issue(r);
        u_dec.idle();
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        check(res.valid, 1'b0);
        check(q_flag, 1'b0);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        run(SDM_DUAL_PRODUCT_SUM, 4'h0, 32'h8000_8000, 32'h8000_8000, 32'h0);
        drain();
        check(q_flag, 1'b1);
    endtask
    task automatic wrap_up();
        $display("Mismatches %0d of %0d checks", n_fail, checks);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        n_fail = 0;
        checks = 0;
        rst_n = 1'b0;
        q_wr_en = 1'b0;
        q_wr_data = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_high_word();
        t_dual();
        t_half();
        t_flag();
        t_reset();
        wrap_up();
    end
endmodule // sdm_unit_tb_top
`default_nettype wire
